// file: hw/pgf_pkg.sv
// Purpose: constants for the pixel grabber and fuse command register slice
// Assumes: AXI4-Lite, 32-bit data, one register per word at index*4
// Notes: register offsets are word indices, byte address is four times the index
package pgf_pkg;
    localparam logic [7:0] IDX_MIN_PIXEL = 8'h0C;
    localparam logic [7:0] IDX_CAPTURE = 8'h0D;
    localparam logic [7:0] IDX_REVISION = 8'h01;
    localparam logic [7:0] IDX_INV_REV = 8'h40;
    localparam logic [7:0] IDX_FUSE_EN = 8'h51;
    localparam logic [7:0] IDX_FUSE_LOC = 8'h52;
    localparam logic [7:0] IDX_FUSE_DATA = 8'h53;
    localparam logic [7:0] IDX_FUSE_CTRL = 8'h54;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int VALID_BIT = 7;
    localparam int FUSE_EN_BIT = 0;
    localparam int CMD_WR_BIT = 0;
    localparam int CMD_RD_BIT = 1;
    localparam int CMD_LOCK_BIT = 3;
    localparam logic [7:0] CMD_MASK = 8'h0B;
    localparam logic [8:0] PIXEL_COUNT = 9'h169;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {FUSE_IDLE, FUSE_BUSY} pgf_fuse_e;
endpackage

// file: hw/pgf_regs.sv
// Purpose: pixel grabber, inverted revision and fuse command front end behind AXI4-Lite
// Assumes: frame_start pulses once per frame; pixels stream with pixel_valid in index order
// Notes: fuse macro reached by a request/done handshake
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/10ps
module pgf_regs #(
    parameter logic [7:0] REVISION_ID = 8'h5A // arbitrary value
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic frame_start,
    input wire logic pixel_valid,
    input wire logic [8:0] pixel_index,
    input wire logic [6:0] pixel_value,
    input wire logic [6:0] frame_min_pixel,
    input wire logic frame_min_valid,
    output logic fuse_req,
    output logic [1:0] fuse_op,
    output logic [7:0] fuse_addr,
    output logic [7:0] fuse_wdata,
    input wire logic fuse_done,
    input wire logic [7:0] fuse_rdata
);
    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_idx;
        logic w_held;
        logic [7:0] w_byte;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [6:0] min_pixel;
        logic armed;
        logic holding;
        logic [6:0] grabbed;
        logic [8:0] grab_idx;
        logic frame_seen;
        logic fuse_en;
        logic [7:0] fuse_loc;
        logic [7:0] fuse_data;
        logic [7:0] fuse_cmd;
        pgf_pkg::pgf_fuse_e state;
        logic fuse_req;
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
    } pgf_state_s;
    pgf_state_s st_r;
    pgf_state_s st_nxt;
    logic wr_fire;
    logic rd_fire;
    logic [7:0] rd_idx;
    logic [7:0] cmd_in;
    logic capture_now;

    // bus handshakes; write fires once both halves are held and no response waits
    assign wr_fire = st_r.aw_held && st_r.w_held && !st_r.bvalid;
    assign rd_fire = s_axi_arvalid && !st_r.rvalid;
    assign rd_idx = s_axi_araddr[9:2];
    assign cmd_in = st_r.w_byte & pgf_pkg::CMD_MASK;
    // a frame's first match against the wanted index is taken, later frames ignored while that pixel is held
    assign capture_now = st_r.armed && !st_r.holding && st_r.frame_seen && pixel_valid
        && pixel_index == st_r.grab_idx;

    // next state
    always_comb
    begin
        st_nxt = st_r;
        if (s_axi_awvalid && !st_r.aw_held)
        begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_idx = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && !st_r.w_held)
        begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_byte = s_axi_wdata[7:0];
            st_nxt.w_lane0 = s_axi_wstrb[0];
        end
        if (st_r.bvalid && s_axi_bready)
        begin
            st_nxt.bvalid = 1'b0;
        end
        if (st_r.rvalid && s_axi_rready)
        begin
            st_nxt.rvalid = 1'b0;
        end
        // statistic from the image pipeline
        if (frame_min_valid)
        begin
            st_nxt.min_pixel = frame_min_pixel;
        end
        // one pixel per frame: frame_seen gates capture to the frame after arming
        if (frame_start)
        begin
            st_nxt.frame_seen = st_r.armed && !st_r.holding;
        end
        if (capture_now)
        begin
            st_nxt.holding = 1'b1;
            st_nxt.grabbed = pixel_value;
            st_nxt.frame_seen = 1'b0;
        end
        // fuse engine: bits drop only on done, so done on a read command also updates the data byte
        if (st_r.state == pgf_pkg::FUSE_BUSY && fuse_done)
        begin
            st_nxt.state = pgf_pkg::FUSE_IDLE;
            st_nxt.fuse_req = 1'b0;
            st_nxt.fuse_cmd = pgf_pkg::RESET_BYTE;
            if (st_r.fuse_cmd[pgf_pkg::CMD_RD_BIT])
            begin
                st_nxt.fuse_data = fuse_rdata;
            end
        end
        // register reads, grabber read has side effects
        if (rd_fire)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = pgf_pkg::RESP_OKAY;
            st_nxt.rdata = 32'h0000_0000;
            unique case (rd_idx)
                pgf_pkg::IDX_MIN_PIXEL: st_nxt.rdata[7:0] = {1'b0, st_r.min_pixel};
                pgf_pkg::IDX_CAPTURE:
                begin
                    if (st_r.holding)
                    begin
                        st_nxt.rdata[7:0] = {1'b1, st_r.grabbed};
                        st_nxt.holding = 1'b0;
                        st_nxt.grab_idx = st_r.grab_idx + 9'h001;
                        // last pixel delivered: stay idle until rewritten
                        st_nxt.armed = (st_r.grab_idx + 9'h001) < pgf_pkg::PIXEL_COUNT;
                    end
                end
                pgf_pkg::IDX_REVISION: st_nxt.rdata[7:0] = REVISION_ID;
                pgf_pkg::IDX_INV_REV: st_nxt.rdata[7:0] = ~REVISION_ID;
                pgf_pkg::IDX_FUSE_EN: st_nxt.rdata[pgf_pkg::FUSE_EN_BIT] = st_r.fuse_en;
                pgf_pkg::IDX_FUSE_LOC: st_nxt.rdata[7:0] = st_r.fuse_loc;
                pgf_pkg::IDX_FUSE_DATA: st_nxt.rdata[7:0] = st_r.fuse_data;
                pgf_pkg::IDX_FUSE_CTRL: st_nxt.rdata[7:0] = st_r.fuse_cmd;
                default: st_nxt.rresp = pgf_pkg::RESP_SLVERR;
            endcase
        end
        // register writes; a byte lane 0 strobe is needed to change anything but the grabber
        if (wr_fire)
        begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = pgf_pkg::RESP_OKAY;
            unique case (st_r.aw_idx)
                pgf_pkg::IDX_CAPTURE:
                begin
                    // any value re-arms, regardless of strobes
                    st_nxt.grab_idx = 9'h000;
                    st_nxt.armed = 1'b1;
                    st_nxt.holding = 1'b0;
                    st_nxt.frame_seen = 1'b0;
                end
                pgf_pkg::IDX_FUSE_EN:
                    if (st_r.w_lane0) st_nxt.fuse_en = st_r.w_byte[pgf_pkg::FUSE_EN_BIT];
                pgf_pkg::IDX_FUSE_LOC:
                    if (st_r.w_lane0) st_nxt.fuse_loc = st_r.w_byte;
                pgf_pkg::IDX_FUSE_DATA:
                    // holder locked while a command runs so the program byte stays put
                    if (st_r.w_lane0 && st_r.state == pgf_pkg::FUSE_IDLE) st_nxt.fuse_data = st_r.w_byte;
                pgf_pkg::IDX_FUSE_CTRL:
                begin
                    // disabled or busy: command dropped, bits stay clear/unchanged
                    if (st_r.w_lane0 && st_r.fuse_en && st_r.state == pgf_pkg::FUSE_IDLE && cmd_in != 8'h00)
                    begin
                        st_nxt.fuse_cmd = cmd_in;
                        st_nxt.state = pgf_pkg::FUSE_BUSY;
                        st_nxt.fuse_req = 1'b1;
                    end
                end
                pgf_pkg::IDX_MIN_PIXEL, pgf_pkg::IDX_REVISION, pgf_pkg::IDX_INV_REV: ;
                default: st_nxt.bresp = pgf_pkg::RESP_SLVERR;
            endcase
        end
        // ready flags registered so each bus output leaves a flip-flop
        st_nxt.aw_rdy = !st_nxt.aw_held;
        st_nxt.w_rdy = !st_nxt.w_held;
        st_nxt.ar_rdy = !st_nxt.rvalid;
        if (!aresetn)
        begin
            st_nxt = '0;
            st_nxt.state = pgf_pkg::FUSE_IDLE;
            st_nxt.aw_rdy = 1'b1;
            st_nxt.w_rdy = 1'b1;
            st_nxt.ar_rdy = 1'b1;
        end
    end

    // single state register
    always_ff @(posedge aclk)
    begin
        st_r <= st_nxt;
    end

    assign s_axi_awready = st_r.aw_rdy;
    assign s_axi_wready = st_r.w_rdy;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.ar_rdy;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign fuse_req = st_r.fuse_req;
    assign fuse_op = {st_r.fuse_cmd[pgf_pkg::CMD_LOCK_BIT], st_r.fuse_cmd[pgf_pkg::CMD_RD_BIT]};
    assign fuse_addr = st_r.fuse_loc;
    assign fuse_wdata = st_r.fuse_data;

    // every read word carries the register in bits 7:0 only
    a_rdata_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    // sync reset clears the bus answers, the statistic and the fuse front end
    a_reset_values: assert property (@(posedge aclk)
        !aresetn |=> !s_axi_rvalid && !s_axi_bvalid && st_r.min_pixel == 7'h00
        && !st_r.fuse_en && st_r.fuse_loc == 8'h00 && st_r.fuse_data == 8'h00)
        else $error("reset values wrong");
    // statistic read: top bit is hard zero
    a_min_top_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_idx == pgf_pkg::IDX_MIN_PIXEL |=> s_axi_rdata[7] == 1'b0)
        else $error("min bit 7 set");

    // grabber read with a pixel in hand: valid flag and one step on the index
    a_grab_valid_read: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_idx == pgf_pkg::IDX_CAPTURE && st_r.holding |=> s_axi_rdata[7]
        && st_r.grab_idx == $past(st_r.grab_idx) + 9'h001)
        else $error("grab read wrong");
    // any grabber write restarts the image at index zero
    a_grab_write_arm: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && st_r.aw_idx == pgf_pkg::IDX_CAPTURE |=> st_r.armed && st_r.grab_idx == 9'h000)
        else $error("grab not rearmed");
    // capture takes the pixel on the bus in that cycle
    a_capture_once: assert property (@(posedge aclk) disable iff (!aresetn)
        capture_now |=> st_r.holding && st_r.grabbed == $past(pixel_value))
        else $error("capture lost");
    // a held pixel is not overwritten by later frames until software takes it
    a_hold_stable: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.holding && !(rd_fire && rd_idx == pgf_pkg::IDX_CAPTURE)
        && !(wr_fire && st_r.aw_idx == pgf_pkg::IDX_CAPTURE)
        |=> st_r.holding && st_r.grabbed == $past(st_r.grabbed))
        else $error("held pixel overwritten");
    // while armed the wanted index stays inside the 19 by 19 array
    a_index_range: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.armed |-> st_r.grab_idx < pgf_pkg::PIXEL_COUNT)
        else $error("grab index out of array");
    // inverted revision is the exact complement
    a_inv_revision: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_idx == pgf_pkg::IDX_INV_REV |=> s_axi_rdata[7:0] == ~REVISION_ID)
        else $error("revision not inverted");

    // no command starts unless the gate bit was set
    a_fuse_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(st_r.fuse_req) |-> $past(st_r.fuse_en))
        else $error("command while disabled");
    // gate clear and idle: the fuse request stays low
    a_disabled_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        !st_r.fuse_en && st_r.state == pgf_pkg::FUSE_IDLE |=> !fuse_req)
        else $error("request while disabled");
    // location write reaches the fuse address lines on the next cycle
    a_loc_to_addr: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && st_r.aw_idx == pgf_pkg::IDX_FUSE_LOC && st_r.w_lane0 |=> fuse_addr == $past(st_r.w_byte))
        else $error("fuse address not loaded");
    // program byte cannot move while a command runs
    a_data_locked: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.state == pgf_pkg::FUSE_BUSY && !fuse_done |=> st_r.fuse_data == $past(st_r.fuse_data))
        else $error("data changed while busy");
    // command bits and request stand until done
    a_cmd_held: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.state == pgf_pkg::FUSE_BUSY && !fuse_done |=> st_r.fuse_cmd == $past(st_r.fuse_cmd) && fuse_req)
        else $error("command dropped early");
    // done clears every command bit and the request
    a_cmd_selfclear: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.state == pgf_pkg::FUSE_BUSY && fuse_done |=> st_r.fuse_cmd == 8'h00 && !fuse_req)
        else $error("command bits stuck");
    // read byte is in the holder by the cycle the read bit drops
    a_read_data_ready: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.state == pgf_pkg::FUSE_BUSY && fuse_done && st_r.fuse_cmd[pgf_pkg::CMD_RD_BIT]
        |=> st_r.fuse_data == $past(fuse_rdata))
        else $error("read data late");
    // past the last pixel the grabber neither arms nor captures
    a_stop_at_end: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.grab_idx == pgf_pkg::PIXEL_COUNT |-> !st_r.armed && !capture_now)
        else $error("grabber ran past end");
endmodule

// file: tb/pgf_regs_test.sv
// Purpose: self-checking bench for the pixel grabber and fuse command registers
// Assumes: AXI4-Lite slave answers at its own pace; one request at a time
// Notes: each frame carries only the wanted pixel and its neighbours, to keep the run short
`timescale 1ns/10ps
module pgf_regs_test;
    localparam logic [7:0] REV = 8'hC3; // arbitrary revision value
    logic aclk, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic fs = 1'b0, pv = 1'b0, fmv = 1'b0, fdone = 1'b0, awr, wrd, bv, arr, rv, freq;
    logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rd, got;
    logic [1:0] bresp, rresp, fop, rsp;
    logic [8:0] pidx = 9'h0;
    logic [6:0] pval = 7'h0, fmin = 7'h0, v;
    logic [7:0] faddr, fwd, frd = 8'h0, a8, d8, r8, c;
    logic [3:0] ws = 4'hF;
    logic [6:0] q[$];
    int n_fail = 0, comparisons = 0, cyc = 0, seed, k;

    pgf_regs #(.REVISION_ID(REV)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .frame_start(fs), .pixel_valid(pv), .pixel_index(pidx),
        .pixel_value(pval), .frame_min_pixel(fmin), .frame_min_valid(fmv), .fuse_req(freq),
        .fuse_op(fop), .fuse_addr(faddr), .fuse_wdata(fwd), .fuse_done(fdone), .fuse_rdata(frd));

    // free-running clock, 10 ns period
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // hang guard, far above the few thousand cycles the run needs
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_fail = n_fail + 1;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk_d(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD t=%0t resp got=%h exp=%h", $time, g, e);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] i, input logic [7:0] d);
        @(posedge aclk);
        awa <= {22'h0, i, 2'h0};
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awr && awv) awv <= 1'b0;
            if (wrd && wv) wv <= 1'b0;
        end
        while (!(bv && br));
        rsp = bresp;
        br <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] i);
        @(posedge aclk);
        ara <= {22'h0, i, 2'h0};
        arv <= 1'b1;
        rr <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arr && arv) arv <= 1'b0;
        end
        while (!(rv && rr));
        got = rd;
        rsp = rresp;
        rr <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] i, input logic [31:0] e);
        axr(i);
        chk_r(rsp, pgf_pkg::RESP_OKAY);
        chk_d(got, e);
    endtask

    // one frame: start pulse, then pixels k-1..k+1 with only k carrying v
    task automatic frame(input int k, input logic [6:0] v);
        int i;
        @(posedge aclk);
        fs <= 1'b1;
        for (i = k - 1; i <= k + 1; i++)
        begin
            @(posedge aclk);
            fs <= 1'b0;
            pv <= (i >= 0 && i <= 360);
            pidx <= 9'(i);
            pval <= (i == k) ? v : 7'($random(seed));
        end
        @(posedge aclk);
        pv <= 1'b0;
    endtask

    initial
    begin
        seed = 32'h4523;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rc(8'h0C, 32'h0);
        rc(8'h0D, 32'h0);
        rc(8'h51, 32'h0);
        rc(8'h52, 32'h0);
        rc(8'h53, 32'h0);
        rc(8'h01, 32'(REV));
        rc(8'h40, {24'h0, ~REV});
        axr(8'h20);
        chk_r(rsp, pgf_pkg::RESP_SLVERR);
        axw(8'h20, 8'h00);
        chk_r(rsp, pgf_pkg::RESP_SLVERR);
        // minimum statistic, then a write that must not disturb it
        v = 7'($random(seed));
        @(posedge aclk);
        fmin <= v;
        fmv <= 1'b1;
        @(posedge aclk);
        fmv <= 1'b0;
        axw(8'h0C, 8'hFF);
        chk_r(rsp, pgf_pkg::RESP_OKAY);
        rc(8'h0C, 32'(v));
        // arm with an arbitrary value; nothing captured yet
        axw(8'h0D, 8'h55);
        axr(8'h0D);
        chk_d(got & 32'h80, 32'h0);
        for (k = 0; k < 361; k++) // host reads until all pixels are in
        begin
            v = 7'($random(seed));
            q.push_back(v);
            frame(k, v);
            rc(8'h0D, 32'h80 | 32'(q.pop_front()));
            axr(8'h0D);
            chk_d(got & 32'h80, 32'h0);
        end
        frame(0, 7'h11);
        axr(8'h0D);
        chk_d(got & 32'h80, 32'h0);
        // re-arm with no byte strobes at all: still a write
        ws <= 4'h0;
        axw(8'h0D, 8'h00);
        ws <= 4'hF;
        v = 7'($random(seed));
        frame(0, v);
        rc(8'h0D, 32'h80 | 32'(v));
        // fuse commands refused while disabled
        axw(8'h54, 8'h01);
        chk_d(32'(freq), 32'h0);
        rc(8'h54, 32'h0);
        axw(8'h51, 8'h01);
        rc(8'h51, 32'h1);
        a8 = 8'($random(seed));
        d8 = 8'($random(seed));
        axw(8'h52, a8);
        axw(8'h53, d8);
        rc(8'h52, 32'(a8));
        rc(8'h53, 32'(d8));
        // lane 0 strobe low: location write must be ignored
        ws <= 4'hE;
        axw(8'h52, ~a8);
        ws <= 4'hF;
        rc(8'h52, 32'(a8));
        // write, read, lock in turn; each bit must stand until done
        for (k = 0; k < 3; k++)
        begin
            r8 = 8'($random(seed));
            c = (k == 0) ? 8'h01 : (k == 1) ? 8'h02 : 8'h08;
            axw(8'h54, c);
            chk_d(32'({freq, fop, faddr, fwd}), 32'({1'b1, 2'(k), a8, d8}));
            rc(8'h54, 32'(c));
            // busy: a second command and a new data byte are both refused
            axw(8'h54, 8'h0B);
            axw(8'h53, ~d8);
            rc(8'h54, 32'(c));
            rc(8'h53, 32'(d8));
            @(posedge aclk);
            fdone <= 1'b1;
            frd <= r8;
            @(posedge aclk);
            fdone <= 1'b0;
            rc(8'h54, 32'h0);
            if (k == 1) d8 = r8;
            rc(8'h53, 32'(d8));
            chk_d(32'(freq), 32'h0);
        end
        // second reset in mid-run: front end registers come back cleared
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rc(8'h51, 32'h0);
        rc(8'h52, 32'h0);
        rc(8'h53, 32'h0);
        rc(8'h0C, 32'h0);
        axw(8'h54, 8'h02);
        chk_d(32'(freq), 32'h0);
        wrap_up();
    end
endmodule
